// [src/tx_mac_control.sv]
// Purpose: transmit control of a csma/cd mac with an apb register port
// Assumes: one 100 MHz clock, synchronous active high reset
// Notes: medium events arrive already on this clock; nvm strap loaded at init
//
// Overview of operation
// - data packets start only while the enable bit is set, pause frames whenever idle; resets to zero
// - clearing enable finishes the current packet, then holds queued data
// - pad bit set extends short packets to 64 bytes of data
// - retry limit counts retransmissions beyond the first, half duplex only
// - binary exponential backoff range clamps after the tenth retry
// - collision span pads with symbols to span plus one byte, any duplex
// - pause request schedules xoff frame; cleared when that frame is sent
// - late collision retry bit retransmits late collisions, ignored full duplex
// - multi fetch bit allows four outstanding reads, else one
// - multi fetch bit is loaded from nvm during initialisation
// - late window 64 bytes slow, 512 at gigabit; off means success
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module tx_mac_control
  import tx_ctl_pkg::*;
#(
  parameter int SLOT_CYCLES = 512
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // initialisation
  input wire logic nvm_load,
  input wire logic nvm_multi_fetch,
  // link status
  input wire logic full_duplex,
  input wire logic [1:0] link_speed,
  // packet queue
  input wire logic pkt_avail,
  input wire logic [15:0] pkt_len,
  output logic pkt_take,
  // medium side
  output logic tx_start,
  output logic [15:0] tx_data_bytes,
  output logic [15:0] tx_total_bytes,
  output logic tx_pause,
  input wire logic tx_done,
  input wire logic collision,
  input wire logic [15:0] bytes_sent,
  // data fetch
  output logic [2:0] fetch_limit,
  output logic tx_abandon
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEND = 3'b001,
    ST_PAUSE = 3'b010,
    ST_BACKOFF = 3'b011,
    ST_NEXT = 3'b100
  } tx_state_t;

  typedef struct packed {
    tx_state_t fsm;
    logic [31:0] ctrl;
    logic [7:0] attempts;
    logic [31:0] wait_cnt;
    logic [15:0] data_bytes;
    logic [15:0] total_bytes;
    logic start;
    logic take;
    logic abandon;
    logic [31:0] rdata;
    logic [15:0] sent_count;
    logic [15:0] abandon_count;
  } ctl_state_t;

  ctl_state_t s_reg;
  ctl_state_t s_next;
  logic [15:0] rnd;
  logic [15:0] span_plus;
  logic [15:0] padded;
  logic [15:0] late_win;
  logic [3:0] exp_k;
  logic [15:0] range_mask;
  logic [31:0] slot_wait;
  logic wr_ctrl;
  logic rd_acc;
  logic half_duplex;

  backoff_lfsr #(
    .WIDTH(16)
  ) u_lfsr (
    .clock(clock),
    .sys_rst(sys_rst),
    .value(rnd)
  );

  // ----------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------
  assign half_duplex = ~full_duplex;
  assign wr_ctrl = psel & penable & pwrite & (paddr == ADDR_TRANSMIT_CONTROL);
  // read data is captured in the setup cycle so it stands at the access edge
  assign rd_acc = psel & ~penable & ~pwrite;
  assign span_plus = {6'h00, s_reg.ctrl[SPAN_HI:SPAN_LO]} + 16'h0001;
  assign late_win = (link_speed == SPEED_GIG) ? LATE_WIN_GIG : LATE_WIN_SLOW;
  // range is 2^min(attempts,10) slots
  assign exp_k = (s_reg.attempts > {4'h0, BACKOFF_CLAMP}) ?
                 BACKOFF_CLAMP : s_reg.attempts[3:0];
  assign range_mask = 16'((32'h1 << exp_k) - 32'h1);
  assign slot_wait = 32'(rnd & range_mask) * 32'(SLOT_CYCLES);

  always_comb begin
    padded = pkt_len;
    if (s_reg.ctrl[BIT_PAD] && pkt_len < MIN_FRAME_BYTES) begin
      padded = MIN_FRAME_BYTES;
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.start = 1'b0;
    s_next.take = 1'b0;
    s_next.abandon = 1'b0;
    // --------------------------------------------------------
    // register writes and read data capture
    // --------------------------------------------------------
    if (wr_ctrl) begin
      s_next.ctrl = pwdata & CTRL_WMASK;
    end
    if (nvm_load) begin
      s_next.ctrl[BIT_MULTI] = nvm_multi_fetch;
    end
    if (rd_acc) begin
      unique case (paddr)
        ADDR_TRANSMIT_CONTROL: s_next.rdata = s_reg.ctrl;
        ADDR_TX_STATUS: s_next.rdata = {s_reg.abandon_count, s_reg.sent_count};
        default: s_next.rdata = PSLVERR_NONE;
      endcase
    end
    // --------------------------------------------------------
    // transmit sequencing
    // --------------------------------------------------------
    unique case (s_reg.fsm)
      ST_IDLE: begin
        // a pause request goes ahead of queued data
        if (s_reg.ctrl[BIT_PAUSE]) begin
          s_next.fsm = ST_PAUSE;
          s_next.start = 1'b1;
        end else if (s_reg.ctrl[BIT_ENABLE] && pkt_avail) begin
          s_next.fsm = ST_SEND;
          s_next.attempts = 8'h00;
          s_next.data_bytes = padded;
          s_next.total_bytes = (padded < span_plus) ? span_plus : padded;
          s_next.start = 1'b1;
        end
      end
      ST_SEND: begin
        // finishes even if enable drops meanwhile
        if (collision && half_duplex) begin
          if (bytes_sent >= late_win && !s_reg.ctrl[BIT_LATE]) begin
            s_next.fsm = ST_NEXT;
            s_next.sent_count = s_reg.sent_count + 16'h0001;
          end else if (s_reg.attempts >= s_reg.ctrl[RETRY_HI:RETRY_LO]) begin
            s_next.fsm = ST_NEXT;
            s_next.abandon = 1'b1;
            s_next.abandon_count = s_reg.abandon_count + 16'h0001;
          end else begin
            s_next.fsm = ST_BACKOFF;
            s_next.attempts = s_reg.attempts + 8'h01;
            s_next.wait_cnt = slot_wait;
          end
        end else if (tx_done) begin
          s_next.fsm = ST_NEXT;
          s_next.sent_count = s_reg.sent_count + 16'h0001;
        end
      end
      ST_BACKOFF: begin
        if (s_reg.wait_cnt == 32'h0000_0000) begin
          s_next.fsm = ST_SEND;
          s_next.start = 1'b1;
        end else begin
          s_next.wait_cnt = s_reg.wait_cnt - 32'h0000_0001;
        end
      end
      ST_PAUSE: begin
        if (tx_done) begin
          s_next.fsm = ST_IDLE;
          // a new request written in the same cycle wins over the self clear
          s_next.ctrl[BIT_PAUSE] = wr_ctrl & pwdata[BIT_PAUSE];
        end
      end
      ST_NEXT: begin
        s_next.fsm = ST_IDLE;
        s_next.take = 1'b1;
      end
      default: s_next.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_reg.fsm <= ST_IDLE;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.attempts <= 8'h00;
      s_reg.wait_cnt <= 32'h0000_0000;
      s_reg.data_bytes <= 16'h0000;
      s_reg.total_bytes <= 16'h0000;
      s_reg.start <= 1'b0;
      s_reg.take <= 1'b0;
      s_reg.abandon <= 1'b0;
      s_reg.rdata <= 32'h0000_0000;
      s_reg.sent_count <= 16'h0000;
      s_reg.abandon_count <= 16'h0000;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign prdata = s_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign pkt_take = s_reg.take;
  assign tx_start = s_reg.start;
  assign tx_pause = (s_reg.fsm == ST_PAUSE);
  assign tx_data_bytes = s_reg.data_bytes;
  assign tx_total_bytes = s_reg.total_bytes;
  assign tx_abandon = s_reg.abandon;
  assign fetch_limit = s_reg.ctrl[BIT_MULTI] ? MAX_FETCH : 3'h1;
endmodule

// [src/tx_ctl_pkg.sv]
// Purpose: shared constants for the transmit control block
// Assumes: 32-bit APB register access, 100 MHz clock
// Notes: one software register plus one status register
package tx_ctl_pkg;
  // ----------------------------------------------------------
  // register map
  // ----------------------------------------------------------
  localparam logic [11:0] ADDR_TRANSMIT_CONTROL = 12'h0400;
  localparam logic [11:0] ADDR_TX_STATUS = 12'h0404;
  // ----------------------------------------------------------
  // transmit_control fields
  // ----------------------------------------------------------
  localparam int BIT_ENABLE = 1;
  localparam int BIT_PAD = 3;
  localparam int RETRY_LO = 4;
  localparam int RETRY_HI = 11;
  localparam int SPAN_LO = 12;
  localparam int SPAN_HI = 21;
  localparam int BIT_PAUSE = 22;
  localparam int BIT_BURST = 23;
  localparam int BIT_LATE = 24;
  localparam int BIT_UNDERRUN = 25;
  localparam int THR_LO = 26;
  localparam int THR_HI = 27;
  localparam int BIT_MULTI = 28;
  localparam logic [31:0] CTRL_WMASK = 32'h1FFF_FFFA;
  // enable 0, pad 1, threshold 1, multi fetch 1 until the nvm load overrides it
  localparam logic [31:0] CTRL_RESET = 32'h1400_0008;
  // ----------------------------------------------------------
  // timing and packet sizes
  // ----------------------------------------------------------
  localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040;
  localparam logic [15:0] LATE_WIN_SLOW = 16'h0040;
  localparam logic [15:0] LATE_WIN_GIG = 16'h0200;
  localparam logic [3:0] BACKOFF_CLAMP = 4'h0A;
  localparam logic [2:0] MAX_FETCH = 3'h4;
  localparam logic [1:0] SPEED_GIG = 2'h2;
  localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;
endpackage

// [src/backoff_lfsr.sv]
// Purpose: pseudo random source for collision backoff
// Assumes: same clock as the transmit control
// Notes: 16-bit galois lfsr, free running
`timescale 1ns/1ps
module backoff_lfsr #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // output
  output logic [WIDTH-1:0] value
);
  typedef struct packed {
    logic [WIDTH-1:0] shift;
  } lfsr_state_t;
  lfsr_state_t state_reg;
  lfsr_state_t state_next;
  localparam logic [WIDTH-1:0] TAPS = 16'hB400;
  localparam logic [WIDTH-1:0] SEED = 16'hACE1;

  always_comb begin
    state_next = state_reg;
    state_next.shift = state_reg.shift >> 1;
    if (state_reg.shift[0]) begin
      state_next.shift = (state_reg.shift >> 1) ^ TAPS;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg.shift <= SEED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value = state_reg.shift;
endmodule

// [dv/tx_ctl_asserts.sv]
// Purpose: port checks for tx_mac_control
// Assumes: control bits change only through apb writes
// Notes: ctl shadows the control register from the bus
`timescale 1ns/1ps
module tx_ctl_asserts
  import tx_ctl_pkg::*;
(
  // apb and link
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic full_duplex,
  input wire logic [2:0] fetch_limit,
  // packet path
  input wire logic [15:0] pkt_len,
  input wire logic pkt_take,
  input wire logic tx_start,
  input wire logic [15:0] tx_data_bytes,
  input wire logic [15:0] tx_total_bytes,
  input wire logic tx_pause,
  input wire logic tx_done,
  input wire logic tx_abandon
);
  logic wr;
  logic busy;
  logic [31:0] ctl;
  logic [15:0] want;
  logic [15:0] span1;
  assign wr = psel && penable && pwrite && paddr == ADDR_TRANSMIT_CONTROL;
  assign want = (ctl[BIT_PAD] && pkt_len < MIN_FRAME_BYTES) ? MIN_FRAME_BYTES : pkt_len;
  assign span1 = {6'h00, ctl[SPAN_HI:SPAN_LO]} + 16'h0001;
  // busy spans a data packet including its retries
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctl <= CTRL_RESET;
      busy <= 1'b0;
    end else begin
      if (wr) begin
        ctl <= pwdata;
      end
      if (tx_start && !tx_pause) begin
        busy <= 1'b1;
      end else if (pkt_take) begin
        busy <= 1'b0;
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_pkt_done;
    tx_done && busy;
  endsequence
  a_start_enabled: assert property (tx_start && !busy && !tx_pause |-> $past(ctl[BIT_ENABLE]))
    else $error("start while disabled");
  a_pad_len: assert property (tx_start && !tx_pause |-> tx_data_bytes == $past(want))
    else $error("data length wrong");
  a_span_pad: assert property (tx_start && !tx_pause |->
    tx_total_bytes == ((tx_data_bytes > $past(span1)) ? tx_data_bytes : $past(span1)))
    else $error("total length wrong");
  a_take_after: assert property (s_pkt_done |-> ##2 pkt_take)
    else $error("no take after done");
  a_start_pulse: assert property (tx_start |=> !tx_start)
    else $error("start held");
  a_abandon_take: assert property (tx_abandon |-> !full_duplex ##1 pkt_take)
    else $error("abandon without take");
  a_fetch_follow: assert property (wr |=>
    fetch_limit == ($past(pwdata[BIT_MULTI]) ? MAX_FETCH : 3'h1))
    else $error("fetch limit wrong");
  a_pause_idle: assert property (tx_pause |-> !busy)
    else $error("pause during packet");
endmodule

// [dv/phy_model.sv]
// Purpose: medium side stand-in for tx_mac_control
// Assumes: one frame at a time
// Notes: collides on the first n_coll attempts of each packet
`timescale 1ns/1ps
module phy_model (
  // from mac
  input wire logic clock,
  input wire logic tx_start,
  input wire logic pkt_take,
  // test controls
  input wire logic [3:0] n_coll,
  input wire logic [15:0] coll_at,
  input wire logic [7:0] wire_len,
  // to mac
  output logic tx_done = 1'b0,
  output logic collision = 1'b0,
  output logic [15:0] bytes_sent = 16'h5a5a
);
  logic [3:0] hits = 4'h0;
  logic [7:0] left = 8'h00;
  logic live = 1'b0;
  always @(posedge clock) begin
    tx_done <= 1'b0;
    collision <= 1'b0;
    // stale count flips so it is never mistaken for a report
    bytes_sent <= ~bytes_sent;
    if (pkt_take) hits <= 4'h0;
    if (tx_start) begin
      live <= 1'b1;
      left <= wire_len;
    end else if (live && left != 8'h00) begin
      left <= left - 8'h01;
    end else if (live) begin
      live <= 1'b0;
      if (hits < n_coll) begin
        collision <= 1'b1;
        bytes_sent <= coll_at;
        hits <= hits + 4'h1;
      end else begin
        tx_done <= 1'b1;
      end
    end
  end
endmodule

// [dv/tb.sv]
// Purpose: self-checking bench for tx_mac_control
// Assumes: slot time shortened to 4 cycles
// Notes: start lengths are checked against a queue of notes
`timescale 1ns/1ps
bind tx_mac_control tx_ctl_asserts i_chk (.clock(clock), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .full_duplex(full_duplex),
  .fetch_limit(fetch_limit), .pkt_len(pkt_len), .pkt_take(pkt_take), .tx_start(tx_start),
  .tx_data_bytes(tx_data_bytes), .tx_total_bytes(tx_total_bytes), .tx_pause(tx_pause),
  .tx_done(tx_done), .tx_abandon(tx_abandon));
module tb
  import tx_ctl_pkg::*;
;
  logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, nvm_load = 0;
  logic nvm_multi_fetch = 0, full_duplex = 1, pkt_avail = 0, pad_on = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic [1:0] link_speed = 0;
  logic [15:0] pkt_len = 64, coll_at = 0, tx_data_bytes, tx_total_bytes, bytes_sent;
  logic [3:0] n_coll = 0;
  logic [7:0] wire_len = 8;
  logic [9:0] span = 0;
  logic [2:0] fetch_limit;
  logic pready, pslverr, pkt_take, tx_start, tx_pause, tx_done, collision, tx_abandon;
  int num_errors = 0, total_checks = 0, starts = 0, aborts = 0, seed = 64789, i;
  logic [31:0] exp_q[$];
  always #5 clock = ~clock;
  tx_mac_control #(.SLOT_CYCLES(4)) i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nvm_load(nvm_load), .nvm_multi_fetch(nvm_multi_fetch),
    .full_duplex(full_duplex), .link_speed(link_speed), .pkt_avail(pkt_avail), .pkt_len(pkt_len),
    .pkt_take(pkt_take), .tx_start(tx_start), .tx_data_bytes(tx_data_bytes),
    .tx_total_bytes(tx_total_bytes), .tx_pause(tx_pause), .tx_done(tx_done),
    .collision(collision), .bytes_sent(bytes_sent), .fetch_limit(fetch_limit),
    .tx_abandon(tx_abandon));
  phy_model i_phy (.clock(clock), .tx_start(tx_start), .pkt_take(pkt_take), .n_coll(n_coll),
    .coll_at(coll_at), .wire_len(wire_len), .tx_done(tx_done), .collision(collision),
    .bytes_sent(bytes_sent));
  task check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_sig(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 5000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 5000) begin
      num_errors++;
      summarize();
    end
  endtask
  // read data is taken at the edge where pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 5000);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 5000) begin
      num_errors++;
      summarize();
    end
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] want);
    apb(1'b0, a, 32'h0000_0000);
    check(rd & mask, want);
  endtask
  // burst and reserved bit 0 are always written as zero
  task wctl(input logic en, input logic late, input logic pause, input logic [7:0] rl);
    apb(1'b1, ADDR_TRANSMIT_CONTROL, {7'h08, late, 1'b0, pause, span, rl, pad_on, 1'b0, en, 1'b0});
  endtask
  task send(input logic [15:0] len, input int want_starts);
    logic [15:0] d, t;
    d = (pad_on && len < 16'h0040) ? 16'h0040 : len;
    t = ({6'h00, span} + 16'h0001 > d) ? {6'h00, span} + 16'h0001 : d;
    exp_q.push_back({d, t});
    starts = 0;
    @(posedge clock);
    pkt_len <= len;
    pkt_avail <= 1'b1;
    wait_sig(tx_start, 1'b1);
    pkt_avail <= 1'b0;
    wait_sig(pkt_take, 1'b1);
    @(posedge clock);
    check(starts, want_starts);
  endtask
  always @(posedge clock) begin
    if (!sys_rst && tx_start === 1'b1 && tx_pause !== 1'b1) begin
      starts++;
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check({tx_data_bytes, tx_total_bytes}, exp_q[0]);
    end
    if (pkt_take === 1'b1 && exp_q.size() != 0) void'(exp_q.pop_front());
    if (tx_abandon === 1'b1) aborts++;
  end
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    rdchk(ADDR_TRANSMIT_CONTROL, 32'h0000_000A, 32'h0000_0008);
    rdchk(12'h7F0, 32'hFFFF_FFFF, 32'h0000_0000);
    for (i = 0; i < 2; i++) begin
      nvm_multi_fetch <= i[0];
      nvm_load <= 1'b1;
      @(posedge clock);
      nvm_load <= 1'b0;
      @(posedge clock);
      check({29'h0, fetch_limit}, i[0] ? 32'h4 : 32'h1);
    end
    for (i = 0; i < 8; i++) begin
      pad_on = i[2];
      span = i[0] ? 10'd99 : 10'd0;
      wctl(1'b1, 1'b0, 1'b0, 8'd15);
      send(i[1:0] == 2'd3 ? 16'd17 + 16'($unsigned($random(seed)) % 1484)
        : (i[1] ? 16'd64 : (i[0] ? 16'd63 : 16'd17)), 1);
    end
    wire_len <= 8'd200;
    fork
      send(16'd300, 1);
      begin
        wait_sig(tx_start, 1'b1);
        wctl(1'b0, 1'b0, 1'b0, 8'd15);
      end
    join
    pkt_avail <= 1'b1;
    repeat (30) @(posedge clock);
    fork
      send(16'd300, 1);
      wctl(1'b1, 1'b0, 1'b0, 8'd15);
    join
    wire_len <= 8'd8;
    full_duplex <= 1'b0;
    coll_at <= 16'd10;
    n_coll <= 4'd15;
    wctl(1'b1, 1'b0, 1'b0, 8'd2);
    send(16'd100, 3);
    check(aborts, 1);
    n_coll <= 4'd1;
    send(16'd100, 2);
    for (i = 0; i < 3; i++) begin
      link_speed <= (i == 2) ? SPEED_GIG : 2'h0;
      coll_at <= (i == 2) ? 16'd511 : 16'd64;
      wctl(1'b1, i == 1, 1'b0, 8'd2);
      send(16'd100, (i == 0) ? 1 : 2);
    end
    full_duplex <= 1'b1;
    n_coll <= 4'd0;
    wctl(1'b1, 1'b0, 1'b1, 8'd15);
    wait_sig(tx_pause, 1'b1);
    wait_sig(tx_pause, 1'b0);
    rdchk(ADDR_TRANSMIT_CONTROL, 32'h0040_0002, 32'h0000_0002);
    summarize();
  end
endmodule
